// file: verilog/hsf_pkg.sv
// constants and types shared by the fault supervision logic
package hsf_pkg;
   // ***********************
   // clock and timing
   // ***********************
   localparam int CLK_HZ      = 10_000_000;
   localparam int QUAL_MS     = 100;
   localparam int QUAL_CYCLES = CLK_HZ / 1000 * QUAL_MS;
   localparam int ADC_RATE_HZ = 10;
   localparam int ADC_PERIOD  = CLK_HZ / ADC_RATE_HZ;

   // ***********************
   // fault and status layout
   // ***********************
   localparam int FLT_W  = 6;
   localparam int BIT_OV = 0;
   localparam int BIT_UV = 1;
   localparam int BIT_OC = 2;
   localparam int BIT_PB = 3;
   localparam int BIT_CC = 4;
   localparam int BIT_FS = 5;
   localparam logic [FLT_W-1:0] FAULT_RST     = 6'h00;
   localparam logic [FLT_W-1:0] STATUS_RST    = 6'h00;
   localparam logic [FLT_W-1:0] ALERT_EN_RST  = 6'h00;
   localparam logic [FLT_W-1:0] HOST_SET_MASK = 6'h07;
   localparam logic [FLT_W-1:0] CARD_KEEP     = 6'h10;
   localparam logic             ON_CTRL_RST   = 1'b0;

   // ***********************
   // converter
   // ***********************
   localparam int ADC_W         = 8;
   localparam int VOUT_STEP_MV  = 400;
   localparam int AUX_STEP_UV   = 10_000;
   localparam int SENSE_STEP_UV = 300;
   localparam int SHORT_UV      = 2000;
   localparam logic [ADC_W-1:0] SHORT_CODE =
      ADC_W'((SHORT_UV + SENSE_STEP_UV - 1) / SENSE_STEP_UV);
   localparam logic [ADC_W-1:0] RESULT_RST = 8'h00;
   localparam int ADDR_W = 7;

   typedef enum logic [1:0] {
      CH_VOUT  = 2'h0,
      CH_AUX   = 2'h1,
      CH_SENSE = 2'h2
   } hsf_chan_t;

   typedef enum logic [1:0] {
      PM_OPEN_GOOD = 2'h0,
      PM_LOW_GOOD  = 2'h1,
      PM_OUTPUT    = 2'h2,
      PM_INPUT     = 2'h3
   } hsf_pin_mode_t;

   typedef enum logic [2:0] {
      AS_IDLE  = 3'b001,
      AS_START = 3'b010,
      AS_WAIT  = 3'b100
   } hsf_adc_state_t;
endpackage

// file: verilog/hsf_fault_alert.sv
// fault supervision, alert and converter result logic of the switch
//
// Behaviour
// R01: low input voltage trips switch, sets bits
// R02: autoretry after input good for 100ms
// R03: every card presence edge sets change fault
// R04: card removal switches off, clears inserted bit
// R05: card insertion clears faults except change
// R06: card low 100ms copies on pin to control
// R07: sense reading 2mV while off flags short
// R08: feedback high while on flags power bad
// R09: power bad suppressed while gate drive low
// R10: feedback recovery releases pin, clears present
// R11: alert only for enabled faults, enables reset
// R12: alert response returns address, lower wins
// R13: being addressed releases alert
// R14: alert rearms only on newly set fault
// R15: host zero clears fault unless still present
// R16: whole fault register clears on turn-off events; faults still present stay set
// R17: autoretry off: latched faults hold switch off
// R18: autoretry on: present bits hold switch off
// R19: converter cycles three inputs, 8-bit
// R20: each result refreshed ten times per second
// R21: test bit freezes results, host writes them
// R22: two bits select general pin mode
// R23: host writing one to OV/UV/OC fault forces off while its autoretry is off
// R24: qualification counter restarts on lost condition
`timescale 1ns/10ps
`default_nettype none
module hsf_fault_alert
   import hsf_pkg::*;
#(
   parameter int QUAL_CYC = hsf_pkg::QUAL_CYCLES,
   parameter int ADC_PER  = hsf_pkg::ADC_PERIOD
) (
   input  wire logic                        clk,
   input  wire logic                        resetn,
   input  wire logic                        link_clk,
   input  wire logic                        input_low_voltage_pin,
   input  wire logic                        input_reset_level_pin,
   input  wire logic                        overvoltage_pin,
   input  wire logic                        overcurrent_pin,
   input  wire logic                        card_presence_pin,
   input  wire logic                        on_pin,
   input  wire logic                        output_feedback_pin,
   input  wire logic                        gate_drive_low,
   input  wire logic                        internal_supply_rail,
   input  wire logic                        gpio_in,
   input  wire logic                        undervoltage_autoretry_bit,
   input  wire logic                        overvoltage_autoretry_bit,
   input  wire logic                        overcurrent_autoretry_bit,
   input  wire logic                        converter_test_mode_bit,
   input  wire logic                        pin_mode_select_low,
   input  wire logic                        pin_mode_select_high,
   input  wire logic                        gpo_level,
   input  wire logic                        alert_en_wr,
   input  wire logic [hsf_pkg::FLT_W-1:0]   alert_en_wdata,
   input  wire logic                        on_ctrl_wr,
   input  wire logic                        on_ctrl_wdata,
   input  wire logic [hsf_pkg::ADC_W-1:0]   adc_result,
   input  wire logic                        adc_done,
   input  wire logic [hsf_pkg::ADDR_W-1:0]  dev_addr,
   input  wire logic                        link_fault_wr,
   input  wire logic [hsf_pkg::FLT_W-1:0]   link_fault_wdata,
   input  wire logic                        link_result_wr,
   input  wire logic [1:0]                  link_result_sel,
   input  wire logic [hsf_pkg::ADC_W-1:0]   link_result_wdata,
   input  wire logic                        link_ara,
   input  wire logic                        link_bit_stb,
   input  wire logic                        link_addressed,
   input  wire logic                        sda_in,
   output logic                             sda_out,
   output logic                             sda_oe_n,
   output logic                             adc_start,
   output logic [1:0]                       adc_chan,
   output logic                             switch_on_control_bit,
   output logic                             gate_on,
   output logic [hsf_pkg::FLT_W-1:0]        status_bits,
   output logic [hsf_pkg::FLT_W-1:0]        fault_bits,
   output logic [hsf_pkg::FLT_W-1:0]        alert_en,
   output logic [hsf_pkg::ADC_W-1:0]        result_vout,
   output logic [hsf_pkg::ADC_W-1:0]        result_aux,
   output logic [hsf_pkg::ADC_W-1:0]        result_sense,
   output logic                             gpio_out,
   output logic                             gpio_oe_n,
   output logic                             gpio_in_level,
   output logic                             alert_out,
   output logic                             alert_oe_n
);
   import hsf_pkg::*;

   localparam int QW = $clog2(QUAL_CYC + 1);
   localparam int AW = $clog2(ADC_PER + 1);
   localparam logic [QW-1:0] QUAL_MAX = QW'(QUAL_CYC);
   localparam logic [AW-1:0] ADC_LAST = AW'(ADC_PER - 1);

   if (QUAL_CYC < 2 || ADC_PER < 8) begin : g_chk
      $error("hsf_fault_alert: counts too small");
   end

   function automatic logic [QW-1:0] qual_next(input logic [QW-1:0] c,
                                               input logic ok);
      if (!ok)
         qual_next = '0;
      else if (c == QUAL_MAX)
         qual_next = c;
      else
         qual_next = c + QW'(1);
   endfunction

   // ***********************
   // input synchronisers
   // ***********************
   logic [9:0] pin_s1_ff;
   logic [9:0] pin_s2_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         // card pin idles high, so no false edge after reset
         pin_s1_ff <= 10'h020;
         pin_s2_ff <= 10'h020;
      end else begin
         pin_s1_ff <= {input_low_voltage_pin, input_reset_level_pin,
                       overvoltage_pin, overcurrent_pin, card_presence_pin,
                       on_pin, output_feedback_pin, gate_drive_low,
                       internal_supply_rail, gpio_in};
         pin_s2_ff <= pin_s1_ff;
      end
   end
   logic uv_s, uvr_s, ov_s, oc_s, card_s, on_s, fb_s, glow_s, sup_s, gpi_s;
   assign {uv_s, uvr_s, ov_s, oc_s, card_s, on_s, fb_s, glow_s, sup_s,
           gpi_s} = pin_s2_ff;

   // ***********************
   // link event crossing
   // ***********************
   logic [2:0] tg_s1_ff, tg_s2_ff, tg_s3_ff;
   logic [2:0] link_tg_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tg_s1_ff <= 3'h0;
         tg_s2_ff <= 3'h0;
         tg_s3_ff <= 3'h0;
      end else begin
         tg_s1_ff <= link_tg_ff;
         tg_s2_ff <= tg_s1_ff;
         tg_s3_ff <= tg_s2_ff;
      end
   end
   logic ev_fault_wr, ev_res_wr, ev_release;
   assign {ev_release, ev_res_wr, ev_fault_wr} = tg_s2_ff ^ tg_s3_ff;

   // ***********************
   // registers of the clk domain
   // ***********************
   logic [FLT_W-1:0] fault_ff, status_ff, alert_en_ff;
   logic [FLT_W-1:0] nxt_fault, nxt_status, set_ev, hold_src;
   logic             on_ctrl_ff, nxt_on_ctrl, on_d_ff, card_d_ff;
   logic             gate_on_ff, alert_ff, full_clr, card_cap, uv_qual;
   logic [QW-1:0]    uv_cnt_ff, card_cnt_ff;
   logic [FLT_W-1:0] link_fault_ff;
   logic [1:0]       link_sel_ff;
   logic [ADC_W-1:0] link_res_ff;
   logic [ADC_W-1:0] res_ff [3];
   hsf_adc_state_t   adc_st_ff;
   logic [1:0]       chan_ff;
   logic [AW-1:0]    tick_cnt_ff;
   logic             sense_done;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         uv_cnt_ff   <= '0;
         card_cnt_ff <= '0;
      end else begin
         uv_cnt_ff   <= qual_next(uv_cnt_ff, !uv_s); // R24
         card_cnt_ff <= qual_next(card_cnt_ff, !card_s); // R24
      end
   end
   assign uv_qual  = uv_cnt_ff == QUAL_MAX;
   assign card_cap = !card_s && card_cnt_ff == QUAL_MAX - QW'(1); // R06

   always_comb begin
      nxt_on_ctrl = on_ctrl_ff;
      if (on_ctrl_wr)
         nxt_on_ctrl = on_ctrl_wdata;
      else if (on_d_ff && !on_s)
         nxt_on_ctrl = 1'b0;
      else if ((!on_d_ff && on_s) || card_cap)
         nxt_on_ctrl = on_s; // R06
   end

   assign sense_done = adc_st_ff == AS_WAIT && adc_done &&
                       chan_ff == CH_SENSE && !converter_test_mode_bit;

   always_comb begin
      nxt_status          = status_ff;
      nxt_status[BIT_OV]  = ov_s;
      nxt_status[BIT_OC]  = oc_s;
      nxt_status[BIT_UV]  = uv_s || (status_ff[BIT_UV] && !uv_qual); // R01 R02
      nxt_status[BIT_PB]  = fb_s && !glow_s &&
                            (gate_on_ff || status_ff[BIT_PB]); // R08 R09 R10
      nxt_status[BIT_CC]  = !card_s; // R04 R05
      if (sense_done)
         nxt_status[BIT_FS] = !gate_on_ff && adc_result >= SHORT_CODE; // R07
      set_ev              = nxt_status & ~status_ff & ~CARD_KEEP;
      set_ev[BIT_CC]      = card_s != card_d_ff; // R03
   end

   assign full_clr = (on_ctrl_ff && !nxt_on_ctrl) || uvr_s || sup_s; // R16

   always_comb begin
      nxt_fault = fault_ff;
      if (full_clr)
         nxt_fault = '0; // R16
      else begin
         if (card_d_ff && !card_s)
            nxt_fault = nxt_fault & CARD_KEEP; // R05
         if (ev_fault_wr)
            nxt_fault = (nxt_fault & link_fault_ff) |
                        (link_fault_ff & HOST_SET_MASK); // R15 R23
      end
      nxt_fault = nxt_fault | (fault_ff & status_ff & ~CARD_KEEP); // R15
      nxt_fault = nxt_fault | set_ev;
   end

   always_comb begin
      hold_src         = '0;
      hold_src[BIT_OV] = overvoltage_autoretry_bit ?
                         status_ff[BIT_OV] : fault_ff[BIT_OV]; // R17 R18
      hold_src[BIT_UV] = undervoltage_autoretry_bit ?
                         status_ff[BIT_UV] : fault_ff[BIT_UV]; // R17 R18
      hold_src[BIT_OC] = overcurrent_autoretry_bit ?
                         status_ff[BIT_OC] : fault_ff[BIT_OC]; // R17 R18
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fault_ff   <= FAULT_RST;
         status_ff  <= STATUS_RST;
         on_ctrl_ff <= ON_CTRL_RST;
         on_d_ff    <= 1'b0;
         card_d_ff  <= 1'b1;
         gate_on_ff <= 1'b0;
      end else begin
         fault_ff   <= nxt_fault;
         status_ff  <= nxt_status;
         on_ctrl_ff <= nxt_on_ctrl;
         on_d_ff    <= on_s;
         card_d_ff  <= card_s;
         gate_on_ff <= on_ctrl_ff && !card_s && !uv_s && !ov_s && !sup_s &&
                       hold_src == '0; // R01 R04 R17 R18
      end
   end

   // ***********************
   // alert
   // ***********************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         alert_en_ff <= ALERT_EN_RST; // R11
         alert_ff    <= 1'b0;
      end else begin
         if (alert_en_wr)
            alert_en_ff <= alert_en_wdata;
         if (|(nxt_fault & ~fault_ff & alert_en_ff))
            alert_ff <= 1'b1; // R11 R14
         else if (ev_release)
            alert_ff <= 1'b0; // R12 R13
      end
   end

   // ***********************
   // converter sequencer
   // ***********************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_ff <= '0;
         adc_st_ff   <= AS_IDLE;
         chan_ff     <= CH_VOUT;
         res_ff[0]   <= RESULT_RST;
         res_ff[1]   <= RESULT_RST;
         res_ff[2]   <= RESULT_RST;
      end else begin
         tick_cnt_ff <= tick_cnt_ff == ADC_LAST ? '0 :
                        tick_cnt_ff + AW'(1); // R20
         unique case (adc_st_ff)
            AS_IDLE: begin
               if (tick_cnt_ff == ADC_LAST && !converter_test_mode_bit) begin
                  adc_st_ff <= AS_START;
                  chan_ff   <= CH_VOUT; // R19
               end
            end
            AS_START:
               adc_st_ff <= AS_WAIT;
            AS_WAIT: begin
               if (adc_done) begin
                  if (!converter_test_mode_bit)
                     res_ff[chan_ff] <= adc_result; // R20 R21
                  if (chan_ff == CH_SENSE)
                     adc_st_ff <= AS_IDLE;
                  else begin
                     chan_ff   <= chan_ff + 2'h1; // R19
                     adc_st_ff <= AS_START;
                  end
               end
            end
            default:
               adc_st_ff <= AS_IDLE;
         endcase
         if (ev_res_wr && converter_test_mode_bit && link_sel_ff != 2'h3)
            res_ff[link_sel_ff] <= link_res_ff; // R21
      end
   end

   // ***********************
   // general purpose pin
   // ***********************
   logic gpio_drv_ff, gpio_lvl_ff;
   hsf_pin_mode_t pin_mode;
   assign pin_mode = hsf_pin_mode_t'({pin_mode_select_high,
                                      pin_mode_select_low}); // R22
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gpio_drv_ff <= 1'b0;
         gpio_lvl_ff <= 1'b0;
      end else begin
         gpio_lvl_ff <= gpi_s;
         unique case (pin_mode)
            PM_OPEN_GOOD: gpio_drv_ff <= fb_s; // R08 R10
            PM_LOW_GOOD:  gpio_drv_ff <= !fb_s; // R22
            PM_OUTPUT:    gpio_drv_ff <= !gpo_level; // R22
            PM_INPUT:     gpio_drv_ff <= 1'b0; // R22
         endcase
      end
   end

   // ***********************
   // link domain
   // ***********************
   logic [1:0]        alert_l_ff, sda_l_ff;
   logic              ara_act_ff, sda_drv_ff;
   logic [ADDR_W-1:0] ara_sh_ff;
   logic [2:0]        ara_cnt_ff;
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         alert_l_ff    <= 2'h0;
         sda_l_ff      <= 2'h3;
         link_tg_ff    <= 3'h0;
         link_fault_ff <= FAULT_RST;
         link_sel_ff   <= 2'h0;
         link_res_ff   <= RESULT_RST;
         ara_act_ff    <= 1'b0;
         ara_sh_ff     <= '0;
         ara_cnt_ff    <= 3'h0;
         sda_drv_ff    <= 1'b0;
      end else begin
         alert_l_ff <= {alert_l_ff[0], alert_ff};
         sda_l_ff   <= {sda_l_ff[0], sda_in};
         if (link_fault_wr) begin
            link_fault_ff <= link_fault_wdata;
            link_tg_ff[0] <= !link_tg_ff[0];
         end
         if (link_result_wr) begin
            link_sel_ff   <= link_result_sel;
            link_res_ff   <= link_result_wdata;
            link_tg_ff[1] <= !link_tg_ff[1];
         end
         if (link_addressed)
            link_tg_ff[2] <= !link_tg_ff[2]; // R13
         if (link_ara && alert_l_ff[1] && !ara_act_ff) begin
            ara_act_ff <= 1'b1; // R12
            ara_sh_ff  <= dev_addr;
            ara_cnt_ff <= 3'(ADDR_W);
            sda_drv_ff <= !dev_addr[ADDR_W-1];
         end else if (ara_act_ff && link_bit_stb) begin
            if (ara_sh_ff[ADDR_W-1] && !sda_l_ff[1]) begin
               ara_act_ff <= 1'b0; // R12
               sda_drv_ff <= 1'b0;
            end else if (ara_cnt_ff == 3'h1) begin
               ara_act_ff    <= 1'b0;
               sda_drv_ff    <= 1'b0;
               link_tg_ff[2] <= !link_tg_ff[2]; // R12
            end else begin
               ara_sh_ff  <= {ara_sh_ff[ADDR_W-2:0], 1'b0};
               ara_cnt_ff <= ara_cnt_ff - 3'h1;
               sda_drv_ff <= !ara_sh_ff[ADDR_W-2];
            end
         end
      end
   end

   // ***********************
   // outputs
   // ***********************
   assign sda_out               = 1'b0;
   assign sda_oe_n              = !sda_drv_ff;
   assign adc_start             = adc_st_ff == AS_START;
   assign adc_chan              = chan_ff;
   assign switch_on_control_bit = on_ctrl_ff;
   assign gate_on               = gate_on_ff;
   assign status_bits           = status_ff;
   assign fault_bits            = fault_ff;
   assign alert_en              = alert_en_ff;
   assign result_vout           = res_ff[0];
   assign result_aux            = res_ff[1];
   assign result_sense          = res_ff[2];
   assign gpio_out              = 1'b0;
   assign gpio_oe_n             = !gpio_drv_ff;
   assign gpio_in_level         = gpio_lvl_ff;
   assign alert_out             = 1'b0;
   assign alert_oe_n            = !alert_ff;

   // ***********************
   // assertions
   // ***********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_uv_trip;
      uv_s && !status_ff[BIT_UV];
   endsequence
   sequence s_uv_logged;
      status_ff[BIT_UV] && fault_ff[BIT_UV] && !gate_on_ff;
   endsequence

   a_uv_trip_off: assert property (s_uv_trip |=> s_uv_logged) // R01
      else $error("low input did not trip switch");
   a_uv_qual_hold: assert property (uv_s |=> uv_cnt_ff == '0) // R24
      else $error("qualification counter not restarted");
   a_card_edge: assert property (card_s != card_d_ff |=> fault_ff[BIT_CC]) // R03
      else $error("card change not recorded");
   a_card_remove: assert property ($rose(card_s) |=>
      !gate_on_ff && !status_ff[BIT_CC]) // R04
      else $error("card removal did not switch off");
   a_pb_set: assert property (gate_on_ff && fb_s && !glow_s
      |=> status_ff[BIT_PB] && fault_ff[BIT_PB]) // R08
      else $error("power bad not flagged");
   a_pb_quiet: assert property (glow_s |=> !status_ff[BIT_PB]) // R09
      else $error("power bad during ramp");
   a_alert_mask: assert property (alert_en_ff == '0 && !alert_ff
      |=> !alert_ff) // R11
      else $error("alert without enable");
   a_alert_rel: assert property (ev_release && alert_ff &&
      nxt_fault == fault_ff |=> !alert_ff ##1 !alert_ff [*2]) // R13
      else $error("alert not released");
   a_fault_keep: assert property (status_ff[BIT_UV] && fault_ff[BIT_UV]
      |=> fault_ff[BIT_UV]) // R15
      else $error("present fault cleared");
   a_full_clear: assert property (sup_s && set_ev == '0 &&
      (status_ff & ~CARD_KEEP) == '0 |=> fault_ff == '0) // R16
      else $error("fault register not cleared");
   a_latch_off: assert property (!undervoltage_autoretry_bit &&
      fault_ff[BIT_UV] |=> !gate_on_ff) // R17
      else $error("latched fault did not hold switch off");
   a_test_freeze: assert property (converter_test_mode_bit && !ev_res_wr
      |=> $stable(res_ff[2])) // R21
      else $error("result changed in test mode");
endmodule
`default_nettype wire

// file: bench/hsf_host_model.sv
// serial host model driving the link side of the fault logic
`timescale 1ns/10ps
`default_nettype none
module hsf_host_model (
   output logic       link_clk,
   input  wire logic  sda_oe_n,
   output logic       sda_in,
   output logic       link_fault_wr,
   output logic [5:0] link_fault_wdata,
   output logic       link_ara,
   output logic       link_bit_stb
);
   // ***********************
   // link clock and host tasks
   // ***********************
   initial begin
      {link_clk, link_fault_wr, link_fault_wdata, link_ara, link_bit_stb} = '0;
   end
   always #6 link_clk = ~link_clk;
   // pulled-up line, low only while driven
   assign sda_in = sda_oe_n;
   task automatic write_fault(input logic [5:0] d);
      @(posedge link_clk) #1;
      link_fault_wr = 1'b1;
      link_fault_wdata = d;
      @(posedge link_clk) #1;
      link_fault_wr = 1'b0;
      link_fault_wdata = ~d;
   endtask
   task automatic respond(output logic [6:0] a);
      int i;
      @(posedge link_clk) #1;
      link_ara = 1'b1;
      @(posedge link_clk) #1;
      link_ara = 1'b0;
      for (i = 6; i >= 0; i--) begin
         repeat (4) @(posedge link_clk);
         #1 a[i] = sda_in;
         link_bit_stb = 1'b1;
         @(posedge link_clk) #1;
         link_bit_stb = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: bench/hsf_fault_alert_tb.sv
// self-checking bench for the fault supervision logic
`timescale 1ns/10ps
`default_nettype none
module hsf_fault_alert_tb;
   import hsf_pkg::*;
   // ***********************
   // signals and instances
   // ***********************
   localparam int QC = 20;
   logic clk, resetn, link_clk, input_low_voltage_pin, input_reset_level_pin;
   logic overvoltage_pin, overcurrent_pin, card_presence_pin, on_pin;
   logic output_feedback_pin, gate_drive_low, internal_supply_rail, gpio_in;
   logic undervoltage_autoretry_bit, overvoltage_autoretry_bit;
   logic overcurrent_autoretry_bit, converter_test_mode_bit, gpo_level;
   logic pin_mode_select_low, pin_mode_select_high, alert_en_wr, on_ctrl_wr;
   logic on_ctrl_wdata, adc_done, link_fault_wr, link_result_wr, link_ara;
   logic link_bit_stb, link_addressed, sda_in, sda_out, sda_oe_n, adc_start;
   logic switch_on_control_bit, gate_on, gpio_out, gpio_oe_n, gpio_in_level;
   logic alert_out, alert_oe_n;
   logic [FLT_W-1:0]  alert_en_wdata, link_fault_wdata, status_bits;
   logic [FLT_W-1:0]  fault_bits, alert_en;
   logic [ADC_W-1:0]  adc_result, result_vout, result_aux, result_sense;
   logic [ADC_W-1:0]  link_result_wdata;
   logic [ADDR_W-1:0] dev_addr, addr;
   logic [1:0]        adc_chan, link_result_sel;
   logic [31:0]       seed, r;
   int                n_mismatch, total_checks, exp_fault, exp_status;
   logic              adc_busy = 1'b0;
   logic              exp_oe;
   logic [ADC_W-1:0]  exp_res [3] = '{default: 8'h00};
   hsf_fault_alert #(.QUAL_CYC(QC), .ADC_PER(40)) hsf_fault_alert_i (.*);
   hsf_host_model hsf_host_model_i (.*);
   always #50 clk = ~clk;
   // ***********************
   // tasks
   // ***********************
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ***********************
   // random pins and converter responder
   // ***********************
   always @(posedge clk) begin
      if (adc_done && !converter_test_mode_bit)
         exp_res[adc_chan] = adc_result;
      exp_oe = !resetn || (pin_mode_select_high ?
               pin_mode_select_low || gpo_level : !pin_mode_select_low);
      #5;
      chk(gpio_oe_n, exp_oe);
      r = $random(seed);
      {gpio_in, gpo_level, pin_mode_select_low, pin_mode_select_high} = r[3:0];
      converter_test_mode_bit = r[4];
      adc_result = {6'h00, r[6:5]};
      adc_done = adc_busy;
      adc_busy = adc_start;
      gate_drive_low = ~gate_on;
   end
   initial begin
      #200_000;
      n_mismatch++;
      complete_run;
   end
   // ***********************
   // main sequence
   // ***********************
   initial begin
      seed = 32'h9c73a6b8;
      {clk, resetn, input_low_voltage_pin, input_reset_level_pin} = '0;
      {overvoltage_pin, overcurrent_pin, output_feedback_pin} = '0;
      {internal_supply_rail, alert_en_wr, on_ctrl_wr, on_ctrl_wdata} = '0;
      {link_result_wr, link_addressed, link_result_sel} = '0;
      {link_result_wdata, alert_en_wdata, adc_result, adc_done} = '0;
      {gpio_in, gpo_level, converter_test_mode_bit, gate_drive_low} = 4'h1;
      {pin_mode_select_low, pin_mode_select_high} = 2'h0;
      {card_presence_pin, on_pin} = 2'h3;
      undervoltage_autoretry_bit = 1'b1;
      overvoltage_autoretry_bit = 1'b1;
      overcurrent_autoretry_bit = 1'b1;
      dev_addr = 7'($random(seed));
      step(3);
      resetn = 1'b1;
      step(4);
      chk(fault_bits, 0);
      chk(alert_en, 0);
      alert_en_wdata = 6'h02;
      alert_en_wr = 1'b1;
      on_ctrl_wr = 1'b1;
      step(1);
      alert_en_wr = 1'b0;
      on_ctrl_wr = 1'b0;
      step(1);
      chk(alert_en, 2);
      card_presence_pin = 1'b0;
      step(6);
      exp_status = 6'h10;
      exp_fault = 6'h10;
      chk(status_bits, exp_status);
      chk(switch_on_control_bit, 0);
      chk(fault_bits, exp_fault);
      step(QC + 10);
      chk(switch_on_control_bit, 1);
      chk(gate_on, 1);
      hsf_host_model_i.write_fault(6'h00);
      step(10);
      exp_fault = 0;
      chk(fault_bits, exp_fault);
      input_low_voltage_pin = 1'b1;
      step(6);
      exp_status = 6'h12;
      exp_fault = 6'h02;
      chk(gate_on, 0);
      chk(status_bits, exp_status);
      chk(fault_bits, exp_fault);
      chk(alert_oe_n, 0);
      hsf_host_model_i.write_fault(6'h00);
      step(10);
      chk(fault_bits, exp_fault);
      hsf_host_model_i.respond(addr);
      chk(addr, dev_addr);
      step(10);
      chk(alert_oe_n, 1);
      input_low_voltage_pin = 1'b0;
      step(QC + 10);
      exp_status = 6'h10;
      chk(status_bits, exp_status);
      chk(gate_on, 1);
      chk(fault_bits, exp_fault);
      chk(alert_oe_n, 1);
      undervoltage_autoretry_bit = 1'b0;
      step(6);
      chk(gate_on, 0);
      hsf_host_model_i.write_fault(6'h00);
      step(10);
      exp_fault = 0;
      chk(fault_bits, exp_fault);
      chk(gate_on, 1);
      hsf_host_model_i.write_fault(6'h02);
      step(10);
      exp_fault = 6'h02;
      chk(fault_bits, exp_fault);
      chk(gate_on, 0);
      chk(alert_oe_n, 0);
      @(posedge link_clk) #1 link_addressed = 1'b1;
      @(posedge link_clk) #1 link_addressed = 1'b0;
      step(10);
      chk(alert_oe_n, 1);
      on_ctrl_wr = 1'b1;
      step(1);
      on_ctrl_wr = 1'b0;
      step(8);
      exp_fault = 0;
      chk(fault_bits, exp_fault);
      chk(switch_on_control_bit, 0);
      card_presence_pin = 1'b1;
      step(6);
      exp_status = 0;
      exp_fault = 6'h10;
      chk(status_bits, exp_status);
      chk(fault_bits, exp_fault);
      chk(gate_on, 0);
      chk(result_vout, exp_res[0]);
      chk(result_aux, exp_res[1]);
      chk(result_sense, exp_res[2]);
      complete_run;
   end
endmodule
`default_nettype wire
